// ==== pmt_timer.v ====
// period match timer with apb register slave
//
// Behaviour
// - 8-bit counter, readable and writable
// - period register, resets to all ones
// - run bit clear stops the counter
// - counter cleared by any reset
// - input is fosc/4 through prescaler
// - count to period, then wrap zero
// - 4-bit postscaler sets match flag
// - scalers cleared by count or control writes and reset
// - control write keeps counter value
// - raw match pulse to serial port
// - counter and match as pwm timebase
// - postscale ratio is field plus one
//
// Our own choice: register access over APB.
`timescale 1ns/1ps
`include "pmt_consts.vh"

module pmt_timer #(
    parameter COUNT_W = 8,
    parameter POST_W = 4
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [`PMT_ADDR_W-1:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    output reg irq,
    output reg shift_clock_pulse,
    output reg [COUNT_W-1:0] pwm_time_base,
    output reg pwm_period_match
);

    // ------------------------------------------------------------
    // functions
    // ------------------------------------------------------------

    function [`PMT_ADDR_W-1:0] byte_addr;
        input [7:0] idx;
        begin
            byte_addr = {{(`PMT_ADDR_W-10){1'b0}}, idx, 2'b00};
        end
    endfunction

    function [31:0] zext8;
        input [7:0] value;
        begin
            zext8 = {24'h0000_00, value};
        end
    endfunction

    // ------------------------------------------------------------
    // registers and nets
    // ------------------------------------------------------------

    reg [COUNT_W-1:0] timer_count;
    reg [COUNT_W-1:0] period_value;
    reg [7:0] timer_control;
    reg [7:0] peripheral_flags;
    reg [7:0] match_irq_enable;
    reg [POST_W-1:0] post_count;
    reg [31:0] next_rdata;
    reg next_slverr;
    reg hit_count;
    reg hit_control;
    reg hit_period;
    reg hit_flags;
    reg hit_enable;
    wire setup;
    wire access;
    wire wr_access;
    wire wr_count;
    wire wr_control;
    wire wr_period;
    wire wr_flags;
    wire wr_enable;
    wire scaler_clear;
    wire timer_run;
    wire [1:0] prescale_select;
    wire [POST_W-1:0] postscale_select;
    wire prescaled_tick;
    wire count_tick;
    wire at_period;
    wire match_event;
    wire post_terminal;
    wire flag_set;
    wire flag_clear;

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------

    assign setup = psel && !penable;
    assign access = psel && penable && pready;
    assign wr_access = access && pwrite && !pslverr;

    always @* begin
        hit_count = (paddr == byte_addr(`PMT_IDX_COUNT));
        hit_control = (paddr == byte_addr(`PMT_IDX_CONTROL));
        hit_period = (paddr == byte_addr(`PMT_IDX_PERIOD));
        hit_flags = (paddr == byte_addr(`PMT_IDX_FLAGS));
        hit_enable = (paddr == byte_addr(`PMT_IDX_ENABLE));
    end

    assign wr_count = wr_access && hit_count;
    assign wr_control = wr_access && hit_control;
    assign wr_period = wr_access && hit_period;
    assign wr_flags = wr_access && hit_flags;
    assign wr_enable = wr_access && hit_enable;

    // unmapped address answers with an error, nothing stored
    always @* begin
        next_rdata = 32'h0000_0000;
        next_slverr = 1'b0;
        if (hit_count) begin
            next_rdata = zext8(timer_count);
        end else if (hit_control) begin
            next_rdata = zext8(timer_control);
        end else if (hit_period) begin
            next_rdata = zext8(period_value);
        end else if (hit_flags) begin
            next_rdata = zext8(peripheral_flags);
        end else if (hit_enable) begin
            next_rdata = zext8(match_irq_enable);
        end else begin
            next_slverr = 1'b1;
        end
    end

    // one wait-free access phase; data captured at setup
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else if (setup) begin
            pready <= 1'b1;
            pslverr <= next_slverr;
            prdata <= pwrite ? 32'h0000_0000 : next_rdata;
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------
    // control fields
    // ------------------------------------------------------------

    assign timer_run = timer_control[`PMT_RUN_BIT];
    assign prescale_select = timer_control[`PMT_PRE_MSB:`PMT_PRE_LSB];
    assign postscale_select = timer_control[`PMT_POST_MSB:`PMT_POST_LSB];

    assign scaler_clear = wr_count || wr_control;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_control <= `PMT_CONTROL_RST;
        end else if (wr_control) begin
            // bit 7 unimplemented, reads zero
            timer_control <= pwdata[7:0] & `PMT_CONTROL_MASK;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            period_value <= `PMT_PERIOD_RST;
        end else if (wr_period) begin
            period_value <= pwdata[COUNT_W-1:0];
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            match_irq_enable <= `PMT_ENABLE_RST;
        end else if (wr_enable) begin
            match_irq_enable <= {6'h00, pwdata[`PMT_MATCH_BIT], 1'b0};
        end
    end

    // ------------------------------------------------------------
    // prescaler
    // ------------------------------------------------------------

    pmt_prescaler u_prescaler (
        .pclk(pclk),
        .presetn(presetn),
        .clear(scaler_clear),
        .run(timer_run),
        .prescale_select(prescale_select),
        .tick(prescaled_tick)
    );

    // ------------------------------------------------------------
    // counter
    // ------------------------------------------------------------

    assign count_tick = prescaled_tick && timer_run && !scaler_clear;
    assign at_period = (timer_count == period_value);
    assign match_event = count_tick && at_period;

    // a software write wins over a tick in the same cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_count <= `PMT_COUNT_RST;
        end else if (wr_count) begin
            timer_count <= pwdata[COUNT_W-1:0];
        end else if (count_tick) begin
            if (at_period) begin
                timer_count <= {COUNT_W{1'b0}};
            end else begin
                timer_count <= timer_count + {{(COUNT_W-1){1'b0}}, 1'b1};
            end
        end
    end

    // ------------------------------------------------------------
    // postscaler
    // ------------------------------------------------------------

    assign post_terminal = match_event && (post_count == postscale_select);

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            post_count <= {POST_W{1'b0}};
        end else if (scaler_clear) begin
            post_count <= {POST_W{1'b0}};
        end else if (post_terminal) begin
            post_count <= {POST_W{1'b0}};
        end else if (match_event) begin
            post_count <= post_count + {{(POST_W-1){1'b0}}, 1'b1};
        end
    end

    // ------------------------------------------------------------
    // flags and interrupt
    // ------------------------------------------------------------

    assign flag_set = post_terminal;
    assign flag_clear = wr_flags && pwdata[`PMT_MATCH_BIT];

    // set beats clear so a coincident match is not lost
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            peripheral_flags <= `PMT_FLAGS_RST;
        end else if (flag_set) begin
            peripheral_flags[`PMT_MATCH_BIT] <= 1'b1;
        end else if (flag_clear) begin
            peripheral_flags[`PMT_MATCH_BIT] <= 1'b0;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(peripheral_flags & match_irq_enable);
        end
    end

    // ------------------------------------------------------------
    // outputs to neighbours
    // ------------------------------------------------------------

    // match taken before the postscaler, one cycle per wrap
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shift_clock_pulse <= 1'b0;
            pwm_period_match <= 1'b0;
            pwm_time_base <= {COUNT_W{1'b0}};
        end else begin
            shift_clock_pulse <= match_event;
            pwm_period_match <= match_event;
            pwm_time_base <= timer_count;
        end
    end

endmodule // pmt_timer

// ==== pmt_consts.vh ====
// constants for the period match timer
`ifndef PMT_CONSTS_VH
`define PMT_CONSTS_VH

// register indices, byte address is four times the index
`define PMT_IDX_FLAGS 8'h0C
`define PMT_IDX_COUNT 8'h11
`define PMT_IDX_CONTROL 8'h12
`define PMT_IDX_ENABLE 8'h8C
`define PMT_IDX_PERIOD 8'h92

// apb address width and word shift
`define PMT_ADDR_W 12
`define PMT_WORD_SHIFT 2

// timer_control field positions
`define PMT_PRE_LSB 0
`define PMT_PRE_MSB 1
`define PMT_RUN_BIT 2
`define PMT_POST_LSB 3
`define PMT_POST_MSB 6
`define PMT_CONTROL_MASK 8'h7F

// flag and enable bit position
`define PMT_MATCH_BIT 1

// reset values
`define PMT_COUNT_RST 8'h00
`define PMT_CONTROL_RST 8'h00
`define PMT_PERIOD_RST 8'hFF
`define PMT_FLAGS_RST 8'h00
`define PMT_ENABLE_RST 8'h00

// timing: pclk is the oscillator, counter input is pclk / 4
`define PMT_PCLK_PERIOD_NS 100
`define PMT_FOSC_DIV 4

// prescaled tick periods in pclk cycles, less one
`define PMT_LIMIT_DIV1 6'h03
`define PMT_LIMIT_DIV4 6'h0F
`define PMT_LIMIT_DIV16 6'h3F

`endif

// ==== pmt_prescaler.v ====
// oscillator quarter divider and selectable prescaler
`timescale 1ns/1ps
`include "pmt_consts.vh"

module pmt_prescaler (
    input wire pclk,
    input wire presetn,
    input wire clear,
    input wire run,
    input wire [1:0] prescale_select,
    output reg tick
);

    reg [5:0] div_count;
    reg [5:0] limit;

    always @* begin
        case (prescale_select)
            2'b00: limit = `PMT_LIMIT_DIV1;
            2'b01: limit = `PMT_LIMIT_DIV4;
            default: limit = `PMT_LIMIT_DIV16;
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_count <= 6'h00;
            tick <= 1'b0;
        end else if (clear) begin
            div_count <= 6'h00;
            tick <= 1'b0;
        end else if (!run) begin
            tick <= 1'b0;
        end else if (div_count >= limit) begin
            div_count <= 6'h00;
            tick <= 1'b1;
        end else begin
            div_count <= div_count + 6'h01;
            tick <= 1'b0;
        end
    end

endmodule // pmt_prescaler

// ==== pmt_timer_sva.sv ====
// assertions on the period match timer ports
`timescale 1ns/1ps
`include "pmt_consts.vh"
module pmt_sva #(
    parameter COUNT_W = 8,
    parameter POST_W = 4
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [`PMT_ADDR_W-1:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire irq,
    input wire shift_clock_pulse,
    input wire [COUNT_W-1:0] pwm_time_base,
    input wire pwm_period_match
);
// ----------------
// helpers
// ----------------
wire acc = psel && penable && pready && pwrite;
wire cnt_wr = acc && paddr == 12'h044;
reg run_q;
// last written run bit, so a frozen counter can be judged
always @(posedge pclk or negedge presetn) begin
    if (!presetn)
        run_q <= 1'b0;
    else if (acc && paddr == 12'h048)
        run_q <= pwdata[2];
end
default clocking cb @(posedge pclk); endclocking
default disable iff (!presetn);
// ----------------
// properties
// ----------------
property p_ready; psel && !penable |=> pready; endproperty
a_ready: assert property (p_ready) else $error("no ready after setup");
property p_once; pready |=> !pready; endproperty
a_once: assert property (p_once) else $error("ready longer than one cycle");
property p_err;
    pready |-> pslverr == !(paddr inside {12'h030, 12'h044, 12'h048, 12'h230, 12'h248});
endproperty
a_err: assert property (p_err) else $error("slave error wrong");
property p_idle; (!pready || pwrite) |-> prdata == 32'h0000_0000; endproperty
a_idle: assert property (p_idle) else $error("read data not zero");
property p_pwm; shift_clock_pulse == pwm_period_match; endproperty
a_pwm: assert property (p_pwm) else $error("pwm match differs");
property p_shift; shift_clock_pulse |=> !shift_clock_pulse; endproperty
a_shift: assert property (p_shift) else $error("shift pulse too long");
property p_wrap; shift_clock_pulse |=> pwm_time_base == 0; endproperty
a_wrap: assert property (p_wrap) else $error("no wrap to zero at match");
property p_step;
    $changed(pwm_time_base) && !$past(cnt_wr) && !$past(cnt_wr, 2)
        |-> pwm_time_base == $past(pwm_time_base) + 1'b1 || pwm_time_base == 0;
endproperty
a_step: assert property (p_step) else $error("count jumped");
property p_stop;
    !run_q && !$past(run_q) && !$past(run_q, 2) && !$past(cnt_wr) && !$past(cnt_wr, 2)
        |-> !shift_clock_pulse && $stable(pwm_time_base);
endproperty
a_stop: assert property (p_stop) else $error("stopped timer moved");
endmodule // pmt_sva
bind pmt_timer pmt_sva #(.COUNT_W(COUNT_W), .POST_W(POST_W)) i_sva (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .shift_clock_pulse(shift_clock_pulse), .pwm_time_base(pwm_time_base),
    .pwm_period_match(pwm_period_match));

// ==== tb_pmt_timer.sv ====
// self-checking bench for the period match timer
`timescale 1ns/1ps
`include "pmt_consts.vh"
module tb_pmt_timer;
reg pclk, presetn, psel, penable, pwrite, er;
reg [11:0] paddr;
reg [31:0] pwdata, rd, v, r2;
wire [31:0] prdata;
wire pready, pslverr, irq, shift_clock_pulse, pwm_period_match;
wire [7:0] pwm_time_base;
integer error_cnt = 0, checked = 0, cyc = 0, seed = 16960, n, np, i;
pmt_timer i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .shift_clock_pulse(shift_clock_pulse),
    .pwm_time_base(pwm_time_base), .pwm_period_match(pwm_period_match));
always #50 pclk = ~pclk;
// ----------------
// tasks
// ----------------
task chk(input [31:0] seen, input [31:0] exp);
    begin
        checked = checked + 1;
        if (seen !== exp) begin
            error_cnt = error_cnt + 1;
            $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
        end
    end
endtask
task complete_run;
    begin
        $display("checks %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    end
endtask
// upper data bits are random: the slave must ignore them
task apb(input w, input [11:0] a, input [7:0] d);
    begin
        @(posedge pclk);
        r2 = $random(seed);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {r2[23:0], d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        // no wait count assumed, a hang is ended by the cycle ceiling
        while (pready !== 1'b1)
            @(posedge pclk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    end
endtask
task rdc(input [11:0] a, input [7:0] exp);
    begin
        apb(1'b0, a, 8'h00);
        chk(rd, {24'h00_0000, exp});
    end
endtask
// pclk cycles from run write until irq is seen high
function integer t_exp(input integer pre, input integer per, input integer post);
    t_exp = (pre == 0 ? 4 : pre == 1 ? 16 : 64) * (per + 1) * (post + 1) + 3;
endfunction
always @(posedge pclk) begin
    cyc = cyc + 1;
    if (cyc == 30000) begin
        error_cnt = error_cnt + 1;
        complete_run;
    end
end
// ----------------
// scenarios
// ----------------
initial begin
    pclk = 0;
    presetn = 0;
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = 0;
    pwdata = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    chk(irq, 0);
    rdc(12'h044, 8'h00);
    rdc(12'h048, 8'h00);
    rdc(12'h248, 8'hff);
    rdc(12'h030, 8'h00);
    rdc(12'h230, 8'h00);
    rdc(12'h0fc, 8'h00);
    chk(er, 1);
    $display("reset values done");
    v = $random(seed);
    apb(1'b1, 12'h044, v[7:0]);
    rdc(12'h044, v[7:0]);
    apb(1'b1, 12'h248, v[15:8]);
    rdc(12'h248, v[15:8]);
    apb(1'b1, 12'h048, 8'hfb);
    rdc(12'h048, 8'h7b);
    rdc(12'h044, v[7:0]);
    $display("register access done");
    for (i = 0; i < 4; i = i + 1) begin
        v = $random(seed);
        // postscale 0..3 or 12..15, so the upper field bits are reached
        v[5:2] = {v[4], v[4], v[3:2]};
        apb(1'b1, 12'h048, 8'h00);
        apb(1'b1, 12'h030, 8'h02);
        apb(1'b1, 12'h230, 8'h02);
        apb(1'b1, 12'h248, {6'h00, v[1:0]});
        apb(1'b1, 12'h044, 8'h00);
        apb(1'b1, 12'h048, {1'b0, v[5:2], 1'b1, i[1:0]});
        n = 0;
        np = 0;
        while (irq !== 1'b1 && n < 5000) begin
            @(posedge pclk);
            n = n + 1;
            np = np + shift_clock_pulse;
        end
        chk(n, t_exp(i, v[1:0], v[5:2]));
        chk(np, v[5:2] + 1);
    end
    $display("scaler timing done");
    apb(1'b1, 12'h048, 8'h00);
    apb(1'b1, 12'h230, 8'h00);
    apb(1'b1, 12'h030, 8'h02);
    apb(1'b1, 12'h248, 8'h00);
    apb(1'b1, 12'h048, 8'h04);
    repeat (20) @(posedge pclk);
    chk(irq, 0);
    rdc(12'h030, 8'h02);
    apb(1'b1, 12'h230, 8'h02);
    repeat (2) @(posedge pclk);
    chk(irq, 1);
    apb(1'b1, 12'h048, 8'h00);
    apb(1'b1, 12'h030, 8'h02);
    repeat (2) @(posedge pclk);
    chk(irq, 0);
    $display("interrupt done");
    apb(1'b1, 12'h248, 8'hff);
    apb(1'b1, 12'h048, 8'h04);
    repeat (100) @(posedge pclk);
    apb(1'b1, 12'h048, 8'h00);
    apb(1'b0, 12'h044, 8'h00);
    v = rd;
    chk(v[7:0] == 8'h00, 0);
    repeat (50) @(posedge pclk);
    rdc(12'h044, v[7:0]);
    $display("stop done");
    apb(1'b1, 12'h248, 8'h05);
    apb(1'b1, 12'h048, 8'h04);
    repeat (30) @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rdc(12'h044, 8'h00);
    rdc(12'h248, 8'hff);
    rdc(12'h048, 8'h00);
    $display("mid-run reset done");
    complete_run;
end
endmodule // tb_pmt_timer
